//--- tafp_host.sv
`timescale 1ns/1ns
`default_nettype none
// host processor model on the register bus; it answers attention by reading status
module tafp_host (
	input wire logic clock, // controller clock
	input wire logic wb_ack_i, // slave ack
	input wire logic [31:0] wb_dat_i, // slave read data
	output logic wb_cyc_o = 1'b0, // cycle
	output logic wb_stb_o = 1'b0, // strobe
	output logic wb_we_o = 1'b0, // write enable
	output logic [7:0] wb_adr_o = 8'h00, // byte address
	output logic [3:0] wb_sel_o = 4'h0, // byte lanes
	output logic [31:0] wb_dat_o = 32'h0 // write data
);
	// one classic cycle; the request stands until ack is sampled at an edge
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clock);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= adr;
		wb_sel_o <= 4'hF;
		wb_dat_o <= wd;
		@(posedge clock);
		while (wb_ack_i !== 1'b1) begin
			@(posedge clock);
		end
		rd = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o <= 1'b0;
		wb_dat_o <= ~wd; // released data no longer shows the old value
	endtask
	// the status read that follows an attention request
	task automatic service_attention(output logic [31:0] rd);
		xfer(1'b0, tafp_pkg::ADR_STATUS1, 32'h0, rd);
	endtask
endmodule
`default_nettype wire

//--- tafp_pkg.sv
`default_nettype none
package tafp_pkg;
	// clock and derived timing
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int SENSE_HZ = 36_000;
	localparam int SENSE_HALF_CYC = CLK_HZ / (2 * SENSE_HZ);
	localparam int OC_QUAL_US = 120;
	localparam int OC_QUAL_CYC = OC_QUAL_US * CLK_MHZ;
	localparam int IMB_QUAL_US = 3200;
	localparam int IMB_QUAL_CYC = IMB_QUAL_US * CLK_MHZ;
	localparam int DIODE_NS = 40;
	localparam int DIODE_CYC_RAW = (DIODE_NS * CLK_MHZ) / 1000;
	localparam int DIODE_CYC = (DIODE_CYC_RAW < 1) ? 1 : DIODE_CYC_RAW;
	localparam int HALF_W = 9;
	localparam int OC_W = 12;
	localparam int IMB_W = 17;
	localparam int DIO_W = 4;
	localparam int ZC_W = 6;
	// register byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_VID1 = 8'h04;
	localparam logic [7:0] ADR_VID2 = 8'h08;
	localparam logic [7:0] ADR_FAULT = 8'h0C;
	localparam logic [7:0] ADR_STATUS1 = 8'h10;
	localparam logic [7:0] ADR_ZONE_P = 8'h14;
	localparam logic [7:0] ADR_ZONE_G = 8'h18;
	localparam logic [7:0] ADR_ZC = 8'h1C;
	// fields and reset values
	localparam int ST1_HOT_BIT = 1;
	localparam int ZONE_CLR_BIT = 5;
	localparam int ZONE_ALERT_BIT = 6;
	localparam int ZONE_HOT_BIT = 7;
	localparam logic [7:0] ST1_RST = 8'h00;
	localparam logic [7:0] ZONE_RST = 8'h00;
	localparam logic [7:0] VID_RST = 8'h00;
	localparam logic [1:0] CFG_RST = 2'h3;
	localparam logic [1:0] PS_RST = 2'h0;
	localparam logic [ZC_W-1:0] ZC_INIT = 6'h20;
	// zone thresholds, 10 mV units, bit i set at or below entry i
	localparam logic [7:0] ZONE_MV [8] = '{8'h78, 8'h70, 8'h6C, 8'h68,
		8'h64, 8'h60, 8'h5C, 8'h58};
	typedef enum logic [1:0] {OV_IDLE, OV_PULL, OV_OFF} tafp_ov_t;
	function automatic logic [7:0] zone_of(input logic [7:0] mv10);
		logic [7:0] z;
		z = 8'h00;
		for (int i = 0; i < 8; i++) begin
			z[i] = (mv10 <= ZONE_MV[i]);
		end
		return z;
	endfunction
	// active phase count from configured count and power state
	function automatic logic [1:0] phases_of(input logic [1:0] cfg, input logic [1:0] ps);
		logic [1:0] c;
		c = (cfg == 2'h0) ? 2'h1 : cfg;
		if (ps[1]) begin
			return 2'h1;
		end
		if (ps[0]) begin
			return (c > 2'h1) ? c - 2'h1 : 2'h1;
		end
		return c;
	endfunction
endpackage
`default_nettype wire

//--- tafp_supervisor.sv
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module tafp_supervisor #(
	parameter int IMB_QUAL_CYCLES = tafp_pkg::IMB_QUAL_CYC // imbalance qualify cycles
) (
	input wire logic clock, // 25 MHz
	input wire logic nrst, // async reset, power-on
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic wb_ack_o, // wishbone ack
	output logic [31:0] wb_dat_o, // read data
	input wire logic regulator_enable_in, // enable pin
	input wire logic [7:0] sense_adc_in, // adc result, 10 mV units
	input wire logic [1:0] oc_cmp_in, // droop over threshold, per output
	input wire logic [1:0] woc_cmp_in, // over 1.5x threshold
	input wire logic [1:0] imb_cmp_in, // phase imbalance over 9 mV
	input wire logic [1:0] ov_cmp_in, // over target plus margin
	input wire logic [1:0] ov_ramp_cmp_in, // over fixed ramp threshold
	input wire logic [1:0] below_target_in, // output below target
	input wire logic [1:0] settled_in, // output ramp settled
	input wire logic [1:0] zc_cmp_in, // phase comparator zero cross
	input wire logic [1:0] diode_cond_in, // body diode conducting
	output logic thermistor_sense_graphics, // 1: current to graphics pin
	output logic attention_n, // attention request, low active
	output logic thermal_hot_n, // thermal hot, low active
	output logic comp_switch_on, // compensator switch closed
	output logic switched_comp_follow, // drive switched node to follow
	output logic [1:0] oc_ref_thirds, // oc reference in thirds
	output logic [1:0] power_good_out, // power good per output
	output logic [1:0] pwm_tristate, // all switches off per output
	output logic [1:0] low_side_hold, // low side forced on
	output logic [1:0] zero_cross_off, // low side off at zero cross
	output logic [2*tafp_pkg::ZC_W-1:0] zc_threshold, // zc thresholds, output 1 low
	output logic [1:0] overcurrent_trip, // latched overcurrent
	output logic [1:0] soft_start, // soft-start in progress
	output logic [7:0] target_voltage_code_1, // target for output 1
	output logic [7:0] target_voltage_code_2 // target for output 2
);
	localparam int NS = 19;
	// two-flop synchronisers for all pin inputs
	logic [NS-1:0] raw, s1_r, s2_r;
	logic [7:0] adc1_r, adc2_r;
	assign raw = {regulator_enable_in, diode_cond_in, zc_cmp_in, settled_in, below_target_in,
		ov_ramp_cmp_in, ov_cmp_in, imb_cmp_in, woc_cmp_in, oc_cmp_in};
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s1_r <= '0;
			s2_r <= '0;
			adc1_r <= 8'h00;
			adc2_r <= 8'h00;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			adc1_r <= sense_adc_in;
			adc2_r <= adc1_r;
		end
	end
	logic [1:0] oc_s, woc_s, imb_s, ov_s, ovr_s, below_s, settled_s, zc_s, dio_s;
	logic en_s;
	assign {en_s, dio_s, zc_s, settled_s, below_s, ovr_s, ov_s, imb_s, woc_s, oc_s} = s2_r;

	// wishbone classic slave, ack one cycle after request
	logic req, ack_r;
	logic [31:0] rdat_r;
	logic [1:0] cfg_r, ps1_r, ps2_r;
	logic [7:0] vid1_r, vid2_r, st1_r, zone_p_r, zone_g_r;
	logic [1:0] cur_fault_r, oc_trip_r, latched;
	localparam int ZCW = tafp_pkg::ZC_W;
	logic [ZCW-1:0] zc_thr_r [2];
	tafp_pkg::tafp_ov_t ov_st_r [2];
	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	logic wr, st1_read;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign st1_read = req && !wb_we_i && (wb_adr_i == tafp_pkg::ADR_STATUS1);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req;
			rdat_r <= 32'h0000_0000;
			if (req && !wb_we_i) begin
				unique case (wb_adr_i)
					tafp_pkg::ADR_CTRL: rdat_r[5:0] <= {ps2_r, ps1_r, cfg_r};
					tafp_pkg::ADR_VID1: rdat_r[7:0] <= vid1_r;
					tafp_pkg::ADR_VID2: rdat_r[7:0] <= vid2_r;
					tafp_pkg::ADR_FAULT: rdat_r[7:0] <= {2'h0, ov_st_r[1] != tafp_pkg::OV_IDLE,
						ov_st_r[0] != tafp_pkg::OV_IDLE, cur_fault_r, oc_trip_r};
					tafp_pkg::ADR_STATUS1: rdat_r[7:0] <= st1_r;
					tafp_pkg::ADR_ZONE_P: rdat_r[7:0] <= zone_p_r;
					tafp_pkg::ADR_ZONE_G: rdat_r[7:0] <= zone_g_r;
					tafp_pkg::ADR_ZC: rdat_r[2*ZCW-1:0] <= {zc_thr_r[1], zc_thr_r[0]};
					default: rdat_r <= 32'h0000_0000; // unmapped reads zero
				endcase
			end
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// control and target registers; a latched-off output keeps its target
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cfg_r <= tafp_pkg::CFG_RST;
			ps1_r <= tafp_pkg::PS_RST;
			ps2_r <= tafp_pkg::PS_RST;
			vid1_r <= tafp_pkg::VID_RST;
			vid2_r <= tafp_pkg::VID_RST;
		end else if (wr) begin
			if (wb_adr_i == tafp_pkg::ADR_CTRL) begin
				{ps2_r, ps1_r, cfg_r} <= wb_dat_i[5:0];
			end
			if (wb_adr_i == tafp_pkg::ADR_VID1 && !latched[0]) begin
				vid1_r <= wb_dat_i[7:0];
			end
			if (wb_adr_i == tafp_pkg::ADR_VID2 && !latched[1]) begin
				vid2_r <= wb_dat_i[7:0];
			end
		end
	end
	assign target_voltage_code_1 = vid1_r;
	assign target_voltage_code_2 = vid2_r;

	// sense current alternation, sample at end of each half period
	logic [tafp_pkg::HALF_W-1:0] half_cnt_r;
	logic gsel_r, half_end;
	assign half_end = (half_cnt_r == tafp_pkg::HALF_W'(tafp_pkg::SENSE_HALF_CYC - 1));
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			half_cnt_r <= '0;
			gsel_r <= 1'b0;
		end else if (half_end) begin
			half_cnt_r <= '0;
			gsel_r <= !gsel_r;
		end else begin
			half_cnt_r <= half_cnt_r + 1'b1;
		end
	end
	assign thermistor_sense_graphics = gsel_r;

	// zone conversion; sampling late in the half lets the pin voltage settle
	logic [7:0] zone_nxt;
	logic p_upd, rise6, rise7, fall6, fall5;
	assign zone_nxt = tafp_pkg::zone_of(adc2_r);
	assign p_upd = half_end && !gsel_r;
	assign rise6 = p_upd && zone_nxt[tafp_pkg::ZONE_ALERT_BIT] && !zone_p_r[tafp_pkg::ZONE_ALERT_BIT];
	assign rise7 = p_upd && zone_nxt[tafp_pkg::ZONE_HOT_BIT] && !zone_p_r[tafp_pkg::ZONE_HOT_BIT];
	assign fall6 = p_upd && !zone_nxt[tafp_pkg::ZONE_ALERT_BIT] && zone_p_r[tafp_pkg::ZONE_ALERT_BIT];
	assign fall5 = p_upd && !zone_nxt[tafp_pkg::ZONE_CLR_BIT] && zone_p_r[tafp_pkg::ZONE_CLR_BIT];
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			zone_p_r <= tafp_pkg::ZONE_RST;
			zone_g_r <= tafp_pkg::ZONE_RST;
		end else if (half_end) begin
			if (gsel_r) begin
				zone_g_r <= zone_nxt;
			end else begin
				zone_p_r <= zone_nxt;
			end
		end
	end

	// status, attention and thermal hot; a new event beats a same-cycle read
	logic att_n_r, hot_n_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st1_r <= tafp_pkg::ST1_RST;
			att_n_r <= 1'b1;
			hot_n_r <= 1'b1;
		end else begin
			if (rise6) begin
				st1_r[tafp_pkg::ST1_HOT_BIT] <= 1'b1;
			end else if (fall5) begin
				st1_r[tafp_pkg::ST1_HOT_BIT] <= 1'b0;
			end
			if (rise6 || fall5) begin
				att_n_r <= 1'b0;
			end else if (st1_read) begin
				att_n_r <= 1'b1;
			end
			if (rise7) begin
				hot_n_r <= 1'b0;
			end else if (fall6) begin
				hot_n_r <= 1'b1;
			end
		end
	end
	assign attention_n = att_n_r;
	assign thermal_hot_n = hot_n_r;

	// phase mode: compensator switch, oc scaling, diode emulation
	logic [1:0] ph1_c, de_c;
	logic sw_r, follow_r;
	logic [1:0] thirds_r;
	assign ph1_c = tafp_pkg::phases_of(cfg_r, ps1_r);
	assign de_c = {ps2_r[1], ps1_r[1]};
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sw_r <= 1'b1;
			follow_r <= 1'b0;
			thirds_r <= tafp_pkg::CFG_RST;
		end else begin
			sw_r <= (ph1_c >= 2'h2);
			follow_r <= (ph1_c < 2'h2);
			thirds_r <= ph1_c;
		end
	end
	assign comp_switch_on = sw_r;
	// own flop, so the follow drive changes on the same edge as the switch
	assign switched_comp_follow = follow_r;
	assign oc_ref_thirds = thirds_r;

	// per-output protection; a current fault on either output latches both
	logic [tafp_pkg::OC_W-1:0] oc_cnt_r [2];
	logic [tafp_pkg::IMB_W-1:0] imb_cnt_r [2];
	logic [1:0] oc_hit, imb_hit, ov_hit, ramp_r;
	logic any_cur;
	assign any_cur = |cur_fault_r;
	always_comb begin
		for (int v = 0; v < 2; v++) begin
			oc_hit[v] = oc_cnt_r[v] == tafp_pkg::OC_W'(tafp_pkg::OC_QUAL_CYC);
			imb_hit[v] = imb_cnt_r[v] == tafp_pkg::IMB_W'(IMB_QUAL_CYCLES);
			ov_hit[v] = ramp_r[v] ? ovr_s[v] : ov_s[v];
			latched[v] = any_cur || ov_st_r[v] != tafp_pkg::OV_IDLE;
		end
	end
	// qualification counters saturate at their limit
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int v = 0; v < 2; v++) begin
				oc_cnt_r[v] <= '0;
				imb_cnt_r[v] <= '0;
			end
		end else begin
			for (int v = 0; v < 2; v++) begin
				oc_cnt_r[v] <= !oc_s[v] ? '0 : oc_hit[v] ? oc_cnt_r[v] : oc_cnt_r[v] + 1'b1;
				imb_cnt_r[v] <= !imb_s[v] ? '0 : imb_hit[v] ? imb_cnt_r[v] : imb_cnt_r[v] + 1'b1;
			end
		end
	end
	// latched current faults and overvoltage sequence, cleared by enable low
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cur_fault_r <= 2'h0;
			oc_trip_r <= 2'h0;
			ramp_r <= 2'h3;
			for (int v = 0; v < 2; v++) begin
				ov_st_r[v] <= tafp_pkg::OV_IDLE;
			end
		end else if (!en_s) begin
			cur_fault_r <= 2'h0;
			oc_trip_r <= 2'h0;
			ramp_r <= 2'h3;
			for (int v = 0; v < 2; v++) begin
				ov_st_r[v] <= tafp_pkg::OV_IDLE;
			end
		end else begin
			for (int v = 0; v < 2; v++) begin
				if (oc_hit[v] || woc_s[v] || imb_hit[v]) begin
					cur_fault_r[v] <= 1'b1;
				end
				if (oc_hit[v]) begin
					oc_trip_r[v] <= 1'b1;
				end
				if (settled_s[v]) begin
					ramp_r[v] <= 1'b0;
				end
				unique case (ov_st_r[v])
					tafp_pkg::OV_IDLE: if (ov_hit[v]) ov_st_r[v] <= tafp_pkg::OV_PULL;
					tafp_pkg::OV_PULL: if (below_s[v]) ov_st_r[v] <= tafp_pkg::OV_OFF;
					tafp_pkg::OV_OFF: if (ov_hit[v]) ov_st_r[v] <= tafp_pkg::OV_PULL;
					default: ov_st_r[v] <= tafp_pkg::OV_IDLE;
				endcase
			end
		end
	end
	// switch and power-good outputs; a current fault on either output stops both
	logic [1:0] pg_r, tri_r, hold_r, zco_r, ss_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pg_r <= 2'h0;
			tri_r <= 2'h3;
			hold_r <= 2'h0;
			zco_r <= 2'h0;
			ss_r <= 2'h0;
		end else begin
			for (int v = 0; v < 2; v++) begin
				pg_r[v] <= en_s && !ramp_r[v] && !latched[v];
				tri_r[v] <= !en_s || any_cur || ov_st_r[v] == tafp_pkg::OV_OFF;
				hold_r[v] <= en_s && !any_cur && ov_st_r[v] == tafp_pkg::OV_PULL;
				zco_r[v] <= de_c[v] && zc_s[v];
				ss_r[v] <= en_s && ramp_r[v] && !latched[v];
			end
		end
	end
	assign power_good_out = pg_r;
	assign pwm_tristate = tri_r;
	assign low_side_hold = hold_r;
	assign zero_cross_off = zco_r;
	assign soft_start = ss_r;
	assign overcurrent_trip = oc_trip_r;

	// adaptive zero-cross: measure diode time after each turn-off, step once per event unless the time equals DIODE_CYC
	logic [tafp_pkg::DIO_W-1:0] dio_cnt_r [2];
	logic [1:0] meas_r, zco_d_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meas_r <= 2'h0;
			zco_d_r <= 2'h0;
			for (int v = 0; v < 2; v++) begin
				dio_cnt_r[v] <= '0;
				zc_thr_r[v] <= tafp_pkg::ZC_INIT;
			end
		end else begin
			zco_d_r <= zco_r;
			for (int v = 0; v < 2; v++) begin
				if (zco_r[v] && !zco_d_r[v]) begin
					meas_r[v] <= 1'b1;
					dio_cnt_r[v] <= '0;
				end else if (meas_r[v] && dio_s[v]) begin
					if (~&dio_cnt_r[v]) dio_cnt_r[v] <= dio_cnt_r[v] + 1'b1;
				end else if (meas_r[v]) begin
					meas_r[v] <= 1'b0;
					if (dio_cnt_r[v] > tafp_pkg::DIO_W'(tafp_pkg::DIODE_CYC)) begin
						if (~&zc_thr_r[v]) zc_thr_r[v] <= zc_thr_r[v] + 1'b1;
					end else if (dio_cnt_r[v] < tafp_pkg::DIO_W'(tafp_pkg::DIODE_CYC)) begin
						if (|zc_thr_r[v]) zc_thr_r[v] <= zc_thr_r[v] - 1'b1;
					end
				end
			end
		end
	end
	assign zc_threshold = {zc_thr_r[1], zc_thr_r[0]};

	a_alert_rise: assert property (@(posedge clock) disable iff (!nrst)
		rise6 |=> !attention_n && st1_r[tafp_pkg::ST1_HOT_BIT])
		else $error("attention not raised on zone bit 6 rise");
	a_alert_release: assert property (@(posedge clock) disable iff (!nrst)
		st1_read && !rise6 && !fall5 |=> attention_n ##1 (attention_n || $past(rise6 || fall5)))
		else $error("attention not released by status read");
	a_hot_set: assert property (@(posedge clock) disable iff (!nrst)
		$rose(zone_p_r[tafp_pkg::ZONE_HOT_BIT]) |-> !thermal_hot_n)
		else $error("thermal hot not asserted");
	a_hot_clear: assert property (@(posedge clock) disable iff (!nrst)
		$rose(thermal_hot_n) |-> $fell(zone_p_r[tafp_pkg::ZONE_ALERT_BIT]))
		else $error("thermal hot released without bit 6 fall");
	a_status_cool: assert property (@(posedge clock) disable iff (!nrst)
		fall5 |=> !st1_r[tafp_pkg::ST1_HOT_BIT] && !attention_n)
		else $error("cooling event not reported");
	a_comp_switch: assert property (@(posedge clock) disable iff (!nrst)
		(ph1_c == 2'h1) |=> !comp_switch_on && switched_comp_follow)
		else $error("compensator switch closed in single phase");
	a_oc_qualify: assert property (@(posedge clock) disable iff (!nrst)
		$rose(oc_trip_r[1]) |-> $past(oc_cnt_r[1]) == tafp_pkg::OC_W'(tafp_pkg::OC_QUAL_CYC))
		else $error("overcurrent declared before qualify time");
	a_woc_fast: assert property (@(posedge clock) disable iff (!nrst)
		woc_s[0] && en_s ##1 en_s |=> pwm_tristate[0] && !power_good_out[0])
		else $error("way overcurrent not acted on at once");
	a_fault_both: assert property (@(posedge clock) disable iff (!nrst)
		cur_fault_r[0] |=> pwm_tristate[1] && !power_good_out[1] && !low_side_hold[1])
		else $error("current fault did not stop both outputs");
	a_ov_pull: assert property (@(posedge clock) disable iff (!nrst)
		ov_st_r[0] == tafp_pkg::OV_PULL && en_s && !any_cur |=> low_side_hold[0] && !power_good_out[0])
		else $error("overvoltage pull-down missing");
	a_vid_hold: assert property (@(posedge clock) disable iff (!nrst)
		wr && latched[0] && wb_adr_i == tafp_pkg::ADR_VID1 |=> $stable(target_voltage_code_1))
		else $error("target changed while latched off");
endmodule
`default_nettype wire

//--- test_thermal_alert_fault_protect.sv
`timescale 1ns/1ns
`default_nettype none
module test_thermal_alert_fault_protect;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic en = 1'b0;
	logic [7:0] adc = 8'hFF;
	logic [1:0] oc = 2'h0, woc = 2'h0, imb = 2'h0, ov = 2'h0, ovr = 2'h0;
	logic [1:0] below = 2'h0, settled = 2'h0, zc = 2'h0, dio = 2'h0;
	logic cyc, stb, we, ack, gsel, att_n, hot_n, sw_on, follow;
	logic [7:0] adr, vid1, vid2;
	logic [3:0] sel;
	logic [31:0] wd, rdat, rd;
	logic [1:0] thirds, pg, tri_s, lhold, zcoff, octrip, sst;
	logic [11:0] zcth;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc_cnt = 0;
	always #20 clock = ~clock;
	tafp_host u_tafp_host (.clock(clock), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
		.wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wd));
	// short imbalance qualification keeps the run brief
	tafp_supervisor #(.IMB_QUAL_CYCLES(50)) u_tafp_supervisor (.clock(clock), .nrst(nrst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wd), .wb_ack_o(ack), .wb_dat_o(rdat), .regulator_enable_in(en),
		.sense_adc_in(adc), .oc_cmp_in(oc), .woc_cmp_in(woc), .imb_cmp_in(imb),
		.ov_cmp_in(ov), .ov_ramp_cmp_in(ovr), .below_target_in(below),
		.settled_in(settled), .zc_cmp_in(zc), .diode_cond_in(dio),
		.thermistor_sense_graphics(gsel), .attention_n(att_n), .thermal_hot_n(hot_n),
		.comp_switch_on(sw_on), .switched_comp_follow(follow), .oc_ref_thirds(thirds),
		.power_good_out(pg), .pwm_tristate(tri_s), .low_side_hold(lhold),
		.zero_cross_off(zcoff), .zc_threshold(zcth), .overcurrent_trip(octrip),
		.soft_start(sst), .target_voltage_code_1(vid1), .target_voltage_code_2(vid2));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string nm);
		u_tafp_host.xfer(1'b0, a, 32'h0, rd);
		chk(nm, rd, exp);
	endtask
	// enable low clears every latched fault, then the rail comes back
	task automatic toggle_enable(input logic [1:0] pg_exp);
		en <= 1'b0;
		w(6);
		en <= 1'b1;
		w(10);
		chk("pg after enable", {30'h0, pg}, {30'h0, pg_exp});
		chk("soft start", {30'h0, sst}, {30'h0, ~pg_exp});
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// cut a hang short; the whole run needs about 7300 cycles
	always @(posedge clock) begin
		cyc_cnt++;
		if (cyc_cnt == 30000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic t_reset();
		chk("zc rst", {20'h0, zcth}, 32'h820);
		chk("tri rst", {30'h0, tri_s}, 32'h3);
		rreg(tafp_pkg::ADR_STATUS1, 32'h0, "status rst");
		rreg(8'h40, 32'h0, "unmapped read");
		chk("att rst", {31'h0, att_n}, 32'h1);
		chk("hot rst", {31'h0, hot_n}, 32'h1);
		chk("pg rst", {30'h0, pg}, 32'h0);
	endtask
	// count settled samples of the graphics half, then realign to a rising edge
	task automatic t_sense();
		int n;
		n = 0;
		@(posedge gsel);
		@(negedge clock);
		while (gsel === 1'b1 && n < 1000) begin
			n++;
			@(negedge clock);
		end
		chk("half period", n, tafp_pkg::SENSE_HALF_CYC);
		@(posedge clock);
	endtask
	task automatic t_thermal();
		adc <= 8'h5C;
		w(800);
		chk("att on bit6", {31'h0, att_n}, 32'h0);
		rreg(tafp_pkg::ADR_ZONE_P, 32'h7F, "zone 7F");
		rreg(tafp_pkg::ADR_ZONE_G, 32'h7F, "zone g 7F");
		u_tafp_host.service_attention(rd);
		chk("status hot", rd, 32'h2);
		w(3);
		chk("att released", {31'h0, att_n}, 32'h1);
		adc <= 8'h54;
		w(800);
		chk("hot on", {31'h0, hot_n}, 32'h0);
		rreg(tafp_pkg::ADR_ZONE_P, 32'hFF, "zone FF");
		adc <= 8'h60;
		w(800);
		chk("hot off", {31'h0, hot_n}, 32'h1);
		chk("att quiet", {31'h0, att_n}, 32'h1);
		adc <= 8'h64;
		w(800);
		chk("att on bit5", {31'h0, att_n}, 32'h0);
		u_tafp_host.service_attention(rd);
		chk("status clear", rd, 32'h0);
	endtask
	// every power state of output 1 with a three-phase configuration
	task automatic t_modes();
		logic [1:0] ps;
		zc <= 2'h3;
		for (int p = 0; p < 4; p++) begin
			ps = p[1:0];
			u_tafp_host.xfer(1'b1, tafp_pkg::ADR_CTRL, {26'h0, ps, ps, 2'h3}, rd);
			w(6);
			chk("thirds", {30'h0, thirds}, (p == 0) ? 32'h3 : (p == 1) ? 32'h2 : 32'h1);
			chk("switch", {31'h0, sw_on}, {31'h0, ~ps[1]});
			chk("follow", {31'h0, follow}, {31'h0, ps[1]});
			chk("zc off", {30'h0, zcoff}, {30'h0, {2{ps[1]}}});
		end
		// no diode time after the first turn-off lowers each threshold one step
		chk("zc short", {20'h0, zcth}, 32'h7DF);
		zc <= 2'h0;
		w(6);
		zc <= 2'h3;
		dio <= 2'h3;
		w(8);
		dio <= 2'h0;
		w(6);
		chk("zc long", {20'h0, zcth}, 32'h820);
		zc <= 2'h0;
		u_tafp_host.xfer(1'b1, tafp_pkg::ADR_CTRL, 32'h3, rd);
	endtask
	task automatic t_faults();
		u_tafp_host.xfer(1'b1, tafp_pkg::ADR_VID1, 32'h33, rd);
		u_tafp_host.xfer(1'b1, tafp_pkg::ADR_VID2, 32'h44, rd);
		chk("vid2 pin", {24'h0, vid2}, 32'h44);
		woc <= 2'h1;
		w(6);
		chk("woc tri", {30'h0, tri_s}, 32'h3);
		chk("woc pg", {30'h0, pg}, 32'h0);
		u_tafp_host.xfer(1'b1, tafp_pkg::ADR_VID1, 32'h55, rd);
		rreg(tafp_pkg::ADR_VID1, 32'h33, "vid locked");
		chk("vid1 pin", {24'h0, vid1}, 32'h33);
		woc <= 2'h0;
		toggle_enable(2'h3);
		oc <= 2'h2;
		w(2900);
		chk("oc early", {30'h0, octrip}, 32'h0);
		w(150);
		chk("oc trip", {30'h0, octrip}, 32'h2);
		chk("oc pg", {30'h0, pg}, 32'h0);
		oc <= 2'h0;
		toggle_enable(2'h3);
		imb <= 2'h1;
		w(30);
		imb <= 2'h0;
		w(4);
		chk("imb short", {30'h0, pg}, 32'h3);
		imb <= 2'h1;
		w(70);
		chk("imb tri", {30'h0, tri_s}, 32'h3);
		imb <= 2'h0;
		toggle_enable(2'h3);
	endtask
	// without settled the rail stays in soft-start, power good low
	task automatic t_ov();
		settled <= 2'h0;
		toggle_enable(2'h0);
		ov <= 2'h1;
		w(6);
		chk("ramp thr", {30'h0, lhold}, 32'h0);
		ovr <= 2'h1;
		w(6);
		chk("ov pull", {30'h0, lhold}, 32'h1);
		ovr <= 2'h0;
		below <= 2'h1;
		w(6);
		chk("ov off", {30'h0, {lhold[0], tri_s[0]}}, 32'h1);
		ovr <= 2'h1;
		below <= 2'h0;
		w(6);
		chk("ov again", {30'h0, lhold}, 32'h1);
		ov <= 2'h0;
		ovr <= 2'h0;
		settled <= 2'h3;
		toggle_enable(2'h3);
		ov <= 2'h1;
		w(6);
		chk("ov settled", {30'h0, lhold}, 32'h1);
		ov <= 2'h0;
		toggle_enable(2'h3);
	endtask
	initial begin
		w(3);
		nrst <= 1'b1;
		w(1);
		t_reset();
		en <= 1'b1;
		settled <= 2'h3;
		w(10);
		t_sense();
		t_thermal();
		t_modes();
		t_faults();
		t_ov();
		report_and_stop();
	end
endmodule
`default_nettype wire
